/* File: src/sic_regs.svh */
// Constants of the synthesiser serial control block
//
// Function
// - 15-bit divider from 16/17 prescaler and counters
// - Reference ratio chosen from sixteen coded values
// - Phase-frequency comparator drives up/down pump pulses
// - Test mode puts halved divider output on port zero
// - Works at standard and fast bus rates
// - Address LSB low writes, high reads
// - Address is 11000, two select bits, R/W
// - Acknowledge address match and every received byte
// - Missing read acknowledge makes internal stop
// - First data bit picks divider or control byte
// - Second byte of a pair follows first's kind
// - Byte pairs repeat without readdressing until stop
// - Stop mid-byte discards the partial byte
// - Divider ratio applied when complete or at stop
// - Divider bytes hold ratio MSB first, control fields
// - Control byte layouts: flag, test, ratio; pump, output, ports
// - Sink, source and off test codes force pump and lock flag values
// - Status byte is indicator, lock flag, six zeros
// - Indicator set on dropout, cleared by read stop
// - Indicator set returns registers to power-up values
// - Lock flag reads one when loop locked
`ifndef SIC_REGS_SVH
`define SIC_REGS_SVH
// ==========================================
// Address and byte layout
`define SIC_ADDR_FIX 5'h18
`define SIC_BYTE_BITS 4'h8
`define SIC_KIND_BIT 7
`define SIC_TEST_LSB 4
`define SIC_PUMP_LSB 6
`define SIC_CON_BIT 5
`define SIC_CCH_BIT 4
// ==========================================
// Power-up values
`define SIC_RST_DIV 15'h00f0
`define SIC_RST_TEST 3'h0
`define SIC_RST_REF 4'h0
`define SIC_RST_PUMP 2'h0
`define SIC_RST_CON 1'b1
`define SIC_RST_CCH 1'b1
`define SIC_RST_PORT 4'h0
// ==========================================
// Test codes and lock timing
`define SIC_TEST_SINK 3'h4
`define SIC_TEST_SOURCE 3'h5
`define SIC_TEST_OFF 3'h6
`define SIC_TEST_PORT0 3'h7
`define SIC_LOCK_N 4'h8
`define SIC_LOCK_WIN 8'h04
`endif

/* File: src/sic_pkg.sv */
// Types of the synthesiser serial control block
package sic_pkg;
  typedef enum logic [2:0] {
    SIC_IDLE = 3'b000,
    SIC_ADDR = 3'b001,
    SIC_ACK = 3'b010,
    SIC_WR = 3'b011,
    SIC_RD = 3'b100,
    SIC_RACK = 3'b101
  } sic_state_e;
  typedef enum logic [1:0] {
    SIC_K_FIRST = 2'b00,
    SIC_K_DIV2 = 2'b01,
    SIC_K_CTL2 = 2'b10
  } sic_kind_e;
  typedef struct packed {
    logic [4:0] pc;
    logic [10:0] mc;
    logic [3:0] ac;
    logic [8:0] rc;
    logic up;
    logic dn;
    logic pu;
    logic pd;
    logic half;
    logic [7:0] err;
    logic [3:0] lc;
    logic locked;
    logic div_tick;
  } sic_core_s;
  typedef struct packed {
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic por_m, por_s, por_d, rf_m, rf_s, rf_d, ref_m, ref_s, ref_d;
    logic [1:0] adr_m;
    logic [1:0] adr_s;
    sic_state_e st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rw;
    logic rd_seen;
    sic_kind_e kind;
    logic [6:0] div_hi;
    logic [14:0] div_ratio;
    logic [2:0] test_sel;
    logic [3:0] ref_ratio_sel;
    logic [1:0] pump_current_sel;
    logic comp_on;
    logic comp_choice;
    logic [3:0] port;
    logic [3:0] port_on;
    logic por;
    logic lock_flag;
    logic sda_low;
    logic sda_val;
  } sic_top_s;
endpackage

/* File: src/sic_pll_core.sv */
// RF divider, reference divider, phase comparator and lock detector
`timescale 1ns/1ps
`include "sic_regs.svh"
module sic_pll_core
  import sic_pkg::*;
#(
  parameter logic [3:0] LOCK_N = `SIC_LOCK_N,
  parameter logic [7:0] LOCK_WIN = `SIC_LOCK_WIN
)(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Input edges and settings
  input wire logic rf_edge_in,
  input wire logic ref_edge_in,
  input wire logic [14:0] div_ratio_in,
  input wire logic [3:0] ref_ratio_sel_in,
  input wire logic [2:0] test_sel_in,
  // Results
  output logic pump_up_out,
  output logic pump_down_out,
  output logic divider_half_out,
  output logic locked_out
);
  sic_core_s s, n;
  logic [8:0] ref_top;
  logic comp_tick;
  logic [10:0] m_val;
  logic [3:0] a_val;

  // ==========================================
  // Reference ratio decode
  always_comb
  begin
    case (ref_ratio_sel_in)
      4'h0: ref_top = 9'h001;
      4'h1: ref_top = 9'h003;
      4'h2: ref_top = 9'h007;
      4'h3: ref_top = 9'h00f;
      4'h4: ref_top = 9'h01f;
      4'h5: ref_top = 9'h03f;
      4'h6: ref_top = 9'h07f;
      4'h7: ref_top = 9'h0ff;
      4'h8: ref_top = 9'h017;
      4'h9: ref_top = 9'h004;
      4'ha: ref_top = 9'h009;
      4'hb: ref_top = 9'h013;
      4'hc: ref_top = 9'h027;
      4'hd: ref_top = 9'h04f;
      4'he: ref_top = 9'h09f;
      default: ref_top = 9'h13f;
    endcase
  end

  assign comp_tick = ref_edge_in && (s.rc >= ref_top);
  assign m_val = div_ratio_in[14:4];
  assign a_val = div_ratio_in[3:0];

  // ==========================================
  // Next state
  always_comb
  begin
    n = s;
    n.div_tick = 1'b0;
    if (rf_edge_in)
    begin
      if (s.pc != 5'h00)
        n.pc = s.pc - 5'h01;
      else if (s.mc <= 11'h001)
      begin
        n.div_tick = 1'b1;
        n.mc = m_val;
        n.ac = a_val;
        n.pc = (a_val != 4'h0) ? 5'h10 : 5'h0f;
      end
      else
      begin
        n.mc = s.mc - 11'h001;
        n.ac = (s.ac != 4'h0) ? s.ac - 4'h1 : 4'h0;
        n.pc = (n.ac != 4'h0) ? 5'h10 : 5'h0f;
      end
    end
    if (ref_edge_in)
      n.rc = comp_tick ? 9'h000 : s.rc + 9'h001;
    n.up = s.up | comp_tick;
    n.dn = s.dn | n.div_tick;
    if (n.up && n.dn)
    begin
      n.up = 1'b0;
      n.dn = 1'b0;
    end
    n.pu = n.up;
    n.pd = n.dn;
    if (test_sel_in == `SIC_TEST_SINK)
    begin
      n.pu = 1'b0;
      n.pd = 1'b1;
    end
    else if (test_sel_in == `SIC_TEST_SOURCE)
    begin
      n.pu = 1'b1;
      n.pd = 1'b0;
    end
    else if (test_sel_in == `SIC_TEST_OFF)
    begin
      n.pu = 1'b0;
      n.pd = 1'b0;
    end
    if (n.div_tick)
      n.half = ~s.half;
    if (s.up || s.dn)
      n.err = (s.err == 8'hff) ? s.err : s.err + 8'h01;
    if (comp_tick)
    begin
      n.err = 8'h00;
      if (s.err > LOCK_WIN)
        n.lc = 4'h0;
      else if (s.lc != LOCK_N)
        n.lc = s.lc + 4'h1;
    end
    n.locked = (n.lc == LOCK_N);
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      s <= '0;
    else
      s <= n;
  end

  assign pump_up_out = s.pu;
  assign pump_down_out = s.pd;
  assign divider_half_out = s.half;
  assign locked_out = s.locked;

  // ==========================================
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  chk_pump_not_both: assert property (test_sel_in[2] == 1'b0 |-> !(s.pu && s.pd))
    else $error("pump up and down together");
  chk_half_toggles: assert property (n.div_tick |=> s.half != $past(s.half))
    else $error("halved output missed a divider tick");
  chk_sink_forced: assert property (test_sel_in == `SIC_TEST_SINK |=> s.pd || test_sel_in != `SIC_TEST_SINK)
    else $error("sink test not forcing pump down");
endmodule

/* File: src/synth_i2c_control.sv */
// Serial control interface and register logic of the synthesiser
`timescale 1ns/1ps
`include "sic_regs.svh"
module synth_i2c_control
  import sic_pkg::*;
#(
  parameter logic [3:0] LOCK_N = `SIC_LOCK_N,
  parameter logic [7:0] LOCK_WIN = `SIC_LOCK_WIN
)(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Straps and detectors
  input wire logic [1:0] addr_sel_bits_in,
  input wire logic por_event_in,
  // Divider inputs
  input wire logic rf_in,
  input wire logic ref_in,
  // Loop controls
  output logic pump_up_out,
  output logic pump_down_out,
  output logic [1:0] pump_current_sel_out,
  output logic comp_clock_out_on_out,
  output logic comp_clock_out_choice_out,
  // Port sinks, bit 0 is port_zero
  output logic [3:0] port_on_out
);
  sic_top_s s, n;
  logic scl_rise, scl_fall, start_cond, stop_cond, por_rise;
  logic core_locked, core_half, core_up, core_dn;
  logic [7:0] stat;

  // ==========================================
  // Bus events
  assign scl_rise = s.scl_s && !s.scl_d;
  assign scl_fall = !s.scl_s && s.scl_d;
  assign start_cond = s.scl_s && s.scl_d && s.sda_d && !s.sda_s;
  assign stop_cond = s.scl_s && s.scl_d && !s.sda_d && s.sda_s;
  assign por_rise = s.por_s && !s.por_d;
  assign stat = {s.por, s.lock_flag, 6'h00};

  // ==========================================
  // Loop core
  sic_pll_core #(
    .LOCK_N(LOCK_N),
    .LOCK_WIN(LOCK_WIN)
  ) u_core (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .rf_edge_in(s.rf_s && !s.rf_d),
    .ref_edge_in(s.ref_s && !s.ref_d),
    .div_ratio_in(s.div_ratio),
    .ref_ratio_sel_in(s.ref_ratio_sel),
    .test_sel_in(s.test_sel),
    .pump_up_out(core_up),
    .pump_down_out(core_dn),
    .divider_half_out(core_half),
    .locked_out(core_locked)
  );

  // ==========================================
  // Next state
  always_comb
  begin
    n = s;
    n.scl_m = scl_in;
    n.scl_s = s.scl_m;
    n.scl_d = s.scl_s;
    n.sda_m = sda_in;
    n.sda_s = s.sda_m;
    n.sda_d = s.sda_s;
    n.por_m = por_event_in;
    n.por_s = s.por_m;
    n.por_d = s.por_s;
    n.rf_m = rf_in;
    n.rf_s = s.rf_m;
    n.rf_d = s.rf_s;
    n.ref_m = ref_in;
    n.ref_s = s.ref_m;
    n.ref_d = s.ref_s;
    n.adr_m = addr_sel_bits_in;
    n.adr_s = s.adr_m;
    // Edges are sampled at the system clock, so both bus rates fit
    if (start_cond)
    begin
      n.st = SIC_ADDR;
      n.bits = 4'h0;
      n.sda_low = 1'b0;
      n.kind = SIC_K_FIRST;
    end
    else if (stop_cond)
    begin
      if (s.kind == SIC_K_DIV2)
        n.div_ratio[14:8] = s.div_hi;
      if (s.rd_seen)
        n.por = 1'b0;
      n.rd_seen = 1'b0;
      n.st = SIC_IDLE;
      n.sda_low = 1'b0;
      n.kind = SIC_K_FIRST;
    end
    else
    begin
      case (s.st)
        SIC_ADDR:
        begin
          if (scl_rise)
          begin
            n.sh = {s.sh[6:0], s.sda_s};
            n.bits = s.bits + 4'h1;
          end
          else if (scl_fall && s.bits == `SIC_BYTE_BITS)
          begin
            n.bits = 4'h0;
            if (s.sh[7:1] == {`SIC_ADDR_FIX, s.adr_s})
            begin
              n.sda_low = 1'b1;
              n.st = SIC_ACK;
              n.rw = s.sh[0];
              n.rd_seen = s.rd_seen | s.sh[0];
            end
            else
              n.st = SIC_IDLE;
          end
        end
        SIC_ACK:
        begin
          if (scl_fall)
          begin
            if (s.rw)
            begin
              n.st = SIC_RD;
              n.sh = stat;
              n.sda_low = ~stat[7];
              n.bits = 4'h1;
            end
            else
            begin
              n.st = SIC_WR;
              n.sda_low = 1'b0;
              n.bits = 4'h0;
            end
          end
        end
        SIC_WR:
        begin
          if (scl_rise)
          begin
            n.sh = {s.sh[6:0], s.sda_s};
            n.bits = s.bits + 4'h1;
          end
          else if (scl_fall && s.bits == `SIC_BYTE_BITS)
          begin
            n.sda_low = 1'b1;
            n.st = SIC_ACK;
            n.bits = 4'h0;
            case (s.kind)
              SIC_K_FIRST:
              begin
                if (s.sh[`SIC_KIND_BIT])
                begin
                  n.test_sel = s.sh[`SIC_TEST_LSB +: 3];
                  n.ref_ratio_sel = s.sh[3:0];
                  n.kind = SIC_K_CTL2;
                end
                else
                begin
                  n.div_hi = s.sh[6:0];
                  n.kind = SIC_K_DIV2;
                end
              end
              SIC_K_DIV2:
              begin
                n.div_ratio = {s.div_hi, s.sh};
                n.kind = SIC_K_FIRST;
              end
              default:
              begin
                n.pump_current_sel = s.sh[`SIC_PUMP_LSB +: 2];
                n.comp_on = s.sh[`SIC_CON_BIT];
                n.comp_choice = s.sh[`SIC_CCH_BIT];
                n.port = s.sh[3:0];
                n.kind = SIC_K_FIRST;
              end
            endcase
          end
        end
        SIC_RD:
        begin
          if (scl_fall)
          begin
            if (s.bits == `SIC_BYTE_BITS)
            begin
              n.sda_low = 1'b0;
              n.st = SIC_RACK;
            end
            else
            begin
              n.sh = {s.sh[6:0], 1'b0};
              n.sda_low = ~s.sh[6];
              n.bits = s.bits + 4'h1;
            end
          end
        end
        SIC_RACK:
        begin
          if (scl_rise)
            n.st = s.sda_s ? SIC_IDLE : SIC_ACK;
        end
        default:
        begin
          n.sda_low = 1'b0;
        end
      endcase
    end
    // Dropout sets the indicator and restores power-up settings
    if (por_rise)
    begin
      n.por = 1'b1;
      n.div_ratio = `SIC_RST_DIV;
      n.test_sel = `SIC_RST_TEST;
      n.ref_ratio_sel = `SIC_RST_REF;
      n.pump_current_sel = `SIC_RST_PUMP;
      n.comp_on = `SIC_RST_CON;
      n.comp_choice = `SIC_RST_CCH;
      n.port = `SIC_RST_PORT;
      n.kind = SIC_K_FIRST;
    end
    n.port_on = n.port;
    if (n.test_sel == `SIC_TEST_PORT0)
      n.port_on[0] = core_half;
    if (n.test_sel == `SIC_TEST_SINK || n.test_sel == `SIC_TEST_SOURCE)
      n.lock_flag = 1'b0;
    else if (n.test_sel == `SIC_TEST_OFF)
      n.lock_flag = 1'b1;
    else
      n.lock_flag = core_locked;
  end

  // ==========================================
  // State register
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      s <= '0;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_d <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_d <= 1'b1;
      s.st <= SIC_IDLE;
      s.kind <= SIC_K_FIRST;
      s.div_ratio <= `SIC_RST_DIV;
      s.test_sel <= `SIC_RST_TEST;
      s.ref_ratio_sel <= `SIC_RST_REF;
      s.pump_current_sel <= `SIC_RST_PUMP;
      s.comp_on <= `SIC_RST_CON;
      s.comp_choice <= `SIC_RST_CCH;
      s.port <= `SIC_RST_PORT;
      s.port_on <= `SIC_RST_PORT;
      s.por <= 1'b1;
    end
    else
      s <= n;
  end

  // ==========================================
  // Outputs
  assign sda_out = s.sda_val;
  assign sda_oe_out = s.sda_low;
  assign pump_up_out = core_up;
  assign pump_down_out = core_dn;
  assign pump_current_sel_out = s.pump_current_sel;
  assign comp_clock_out_on_out = s.comp_on;
  assign comp_clock_out_choice_out = s.comp_choice;
  assign port_on_out = s.port_on;

  // ==========================================
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  chk_read_select: assert property (s.st == SIC_ACK && scl_fall && s.rw && !start_cond
    && !stop_cond |=> s.st == SIC_RD)
    else $error("read address did not enter read");
  chk_addr_ack: assert property (s.st == SIC_ADDR && scl_fall && s.bits == 4'h8
    && s.sh[7:1] == {5'h18, s.adr_s} && !por_rise |=> sda_oe_out)
    else $error("matching address not acknowledged");
  chk_addr_miss: assert property (s.st == SIC_ADDR && scl_fall && s.bits == 4'h8
    && s.sh[7:1] != {5'h18, s.adr_s} |=> s.st == SIC_IDLE && !sda_oe_out)
    else $error("foreign address answered");
  chk_nack_stops: assert property (s.st == SIC_RACK && scl_rise && s.sda_s
    |=> s.st == SIC_IDLE && !sda_oe_out)
    else $error("read continued after missing acknowledge");
  chk_status_msb: assert property (s.st == SIC_ACK && scl_fall && s.rw && !start_cond
    && !stop_cond |=> sda_oe_out == !$past(s.por))
    else $error("status msb not the indicator");
  chk_ratio_atomic: assert property ($changed(s.div_ratio) |-> $past(s.kind) == SIC_K_DIV2
    || $past(por_rise))
    else $error("divider changed before ratio complete");
  chk_por_clear: assert property (stop_cond && s.rd_seen && !por_rise |=> !s.por)
    else $error("indicator not cleared by read stop");
  chk_por_restore: assert property (por_rise |=> s.por && s.port == 4'h0
    && s.test_sel == 3'h0 && s.comp_on)
    else $error("registers not restored on dropout");
  chk_lock_test: assert property (s.test_sel == 3'h6 ##1 s.test_sel == 3'h6
    |-> s.lock_flag)
    else $error("pump-off test lock flag not one");
  chk_ack_release: assert property (s.st == SIC_ACK && scl_fall && !s.rw
    |=> !sda_oe_out)
    else $error("write acknowledge not released");
  chk_kind_ctl: assert property (s.st == SIC_WR && scl_fall && s.bits == 4'h8
    && s.kind == SIC_K_FIRST && s.sh[7] && !por_rise |=> s.kind == SIC_K_CTL2)
    else $error("control byte not recognised");
  chk_kind_div: assert property (s.st == SIC_WR && scl_fall && s.bits == 4'h8
    && s.kind == SIC_K_FIRST && !s.sh[7] && !por_rise |=> s.kind == SIC_K_DIV2)
    else $error("divider byte not followed by its partner");
  chk_pair_done: assert property (s.st == SIC_WR && scl_fall && s.bits == 4'h8
    && s.kind != SIC_K_FIRST |=> s.kind == SIC_K_FIRST && s.st == SIC_ACK)
    else $error("pairing not restarted after second byte");
  chk_ratio_apply: assert property (s.st == SIC_WR && scl_fall && s.bits == 4'h8
    && s.kind == SIC_K_DIV2 && !por_rise |=> s.div_ratio == {$past(s.div_hi), $past(s.sh)})
    else $error("divider ratio not taken from both bytes");
  chk_partial_drop: assert property (stop_cond && s.st == SIC_WR && s.bits != 4'h8
    && !por_rise |=> s.port == $past(s.port) && s.test_sel == $past(s.test_sel))
    else $error("partial byte changed settings");
  chk_port_zero: assert property (s.test_sel == 3'h7
    |-> port_on_out[0] == $past(core_half))
    else $error("port zero not following halved divider");
  chk_status_zeros: assert property (s.st == SIC_RD && s.bits > 4'h2
    |-> sda_oe_out)
    else $error("status low bits not zero");
  cov_write_pair: cover property (s.st == SIC_WR && s.kind == SIC_K_DIV2 ##[1:400]
    $changed(s.div_ratio));
  cov_read_status: cover property (s.st == SIC_RD ##[1:400] s.st == SIC_RACK);
  cov_port_test: cover property (s.test_sel == 3'h7 && $changed(port_on_out[0]));
  cov_dropout: cover property (por_rise ##1 s.por);
endmodule

/* File: verif/sic_bus_host.sv */
// Bus controller model that drives the block's two-wire pins
`timescale 1ns/1ps
module sic_bus_host (
  // Bus pins
  output logic scl_out,
  output logic sda_low_out,
  input wire logic sda_in
);
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // ==========================================
  // Bit and bus conditions
  // Low 40 ns, high 24 ns: data settles well before each rise
  task automatic put_bit(input logic b, output logic seen);
    sda_low_out = !b;
    #8;
    scl_out = 1'b1;
    #22;
    seen = sda_in;
    #2;
    scl_out = 1'b0;
    #32;
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    #8;
    scl_out = 1'b1;
    #24;
    sda_low_out = 1'b1;
    #24;
    scl_out = 1'b0;
    #32;
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    #8;
    scl_out = 1'b1;
    #24;
    sda_low_out = 1'b0;
    #32;
  endtask
  // ==========================================
  // Whole bytes
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], s);
    put_bit(1'b1, ack);
  endtask
  // Acking asks for another status byte
  task automatic rd_byte(input logic ack_low, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(1'b1, d[i]);
    put_bit(!ack_low, s);
  endtask
endmodule

/* File: verif/tb_synth_i2c_control.sv */
// Self-checking bench of the synthesiser serial control block
`timescale 1ns/1ps
`include "sic_regs.svh"
module tb_synth_i2c_control;
  import sic_pkg::*;
  logic clock_in, sys_rst_in, scl, host_low, sda_wire, por_ev, rf, refc;
  logic pu, pd, con, cch, dev_sda, dev_oe;
  logic [1:0] addr_sel, psel;
  logic [3:0] ports;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  // Open-drain wire with pull-up
  assign sda_wire = !host_low && !(dev_oe && !dev_sda);
  synth_i2c_control #(.LOCK_N(4'h2), .LOCK_WIN(`SIC_LOCK_WIN)) u_synth_i2c_control (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(dev_sda), .sda_oe_out(dev_oe), .addr_sel_bits_in(addr_sel),
    .por_event_in(por_ev), .rf_in(rf), .ref_in(refc), .pump_up_out(pu),
    .pump_down_out(pd), .pump_current_sel_out(psel), .comp_clock_out_on_out(con),
    .comp_clock_out_choice_out(cch), .port_on_out(ports));
  sic_bus_host u_sic_bus_host (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda_wire));
  // ==========================================
  // Clock, timeout and common tasks
  initial
  begin
    clock_in = 1'b0;
    forever #4 clock_in = !clock_in;
  end
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic write_bytes(input logic [7:0] q[$]);
    logic a;
    u_sic_bus_host.start();
    u_sic_bus_host.wr_byte({5'h18, addr_sel, 1'b0}, a);
    chk("address ack", 16'h0, {15'h0, a});
    foreach (q[i])
    begin
      u_sic_bus_host.wr_byte(q[i], a);
      chk("data ack", 16'h0, {15'h0, a});
    end
    u_sic_bus_host.stop();
    tick(8);
  endtask
  task automatic read_status(input logic [7:0] exp, input int n);
    logic a;
    logic [7:0] d;
    u_sic_bus_host.start();
    u_sic_bus_host.wr_byte({5'h18, addr_sel, 1'b1}, a);
    chk("read address ack", 16'h0, {15'h0, a});
    for (int i = 0; i < n; i++)
    begin
      u_sic_bus_host.rd_byte(i < n - 1, d);
      chk("status byte", {8'h0, exp}, {8'h0, d});
    end
    u_sic_bus_host.rd_byte(1'b0, d);
    chk("silent after nack", 16'hff, {8'h0, d});
    u_sic_bus_host.stop();
    tick(8);
  endtask
  function automatic logic [15:0] ctl();
    return {8'h0, psel, con, cch, ports};
  endfunction
  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk("reset controls", {8'h0, `SIC_RST_PUMP, `SIC_RST_CON, `SIC_RST_CCH, `SIC_RST_PORT},
      ctl());
    read_status(8'h80, 2);
    read_status(8'h00, 1);
  endtask
  task automatic t_pairs();
    write_bytes('{8'h8b, 8'ha6, 8'h80, 8'h63});
    chk("second control pair", 16'h63, ctl());
  endtask
  task automatic t_partial();
    logic s;
    u_sic_bus_host.start();
    u_sic_bus_host.wr_byte({5'h18, addr_sel, 1'b0}, s);
    u_sic_bus_host.wr_byte(8'h80, s);
    for (int i = 0; i < 4; i++)
      u_sic_bus_host.put_bit(1'b1, s);
    u_sic_bus_host.stop();
    tick(8);
    chk("partial byte dropped", 16'h63, ctl());
  endtask
  task automatic t_address();
    logic a;
    for (int k = 0; k < 4; k++)
    begin
      addr_sel = 2'(k);
      tick(4);
      u_sic_bus_host.start();
      u_sic_bus_host.wr_byte({5'h18, addr_sel ^ 2'h1, 1'b0}, a);
      chk("foreign address ack", 16'h1, {15'h0, a});
      u_sic_bus_host.wr_byte(8'h80, a);
      u_sic_bus_host.wr_byte(8'hff, a);
      u_sic_bus_host.stop();
      tick(8);
      chk("foreign data ignored", (k == 0) ? 16'h63 : {8'h0, 2'(k - 1), 6'h25}, ctl());
      write_bytes('{8'h80, {addr_sel, 6'h25}});
      chk("control byte two", {8'h0, addr_sel, 6'h25}, ctl());
    end
    addr_sel = 2'h2;
    tick(4);
  endtask
  task automatic t_tests();
    logic [2:0] code [3] = '{`SIC_TEST_SINK, `SIC_TEST_SOURCE, `SIC_TEST_OFF};
    logic [1:0] pump [3] = '{2'b01, 2'b10, 2'b00};
    logic [7:0] stat [3] = '{8'h00, 8'h00, 8'h40};
    for (int i = 0; i < 3; i++)
    begin
      write_bytes('{{1'b1, code[i], 4'h0}});
      tick(10);
      chk("forced pumps", {14'h0, pump[i]}, {14'h0, pu, pd});
      read_status(stat[i], 1);
    end
  endtask
  task automatic t_divider();
    int edges;
    int marks[$];
    logic last;
    write_bytes('{8'h00, 8'h32, 8'hf0});
    last = ports[0];
    edges = 0;
    while (marks.size() < 3 && edges < 400)
    begin
      rf = 1'b1;
      refc = 1'b1;
      tick(3);
      rf = 1'b0;
      refc = 1'b0;
      tick(3);
      edges++;
      if (ports[0] !== last)
      begin
        marks.push_back(edges);
        last = ports[0];
      end
    end
    chk("port zero toggles", 16'h3, 16'(marks.size()));
    chk("edges per half period", 16'd50, 16'(marks[2] - marks[1]));
  endtask
  task automatic t_dropout();
    por_ev = 1'b1;
    tick(4);
    por_ev = 1'b0;
    tick(8);
    chk("controls after dropout", 16'h30, ctl());
    write_bytes('{8'he0});
    read_status(8'hc0, 1);
    read_status(8'h40, 1);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    sys_rst_in = 1'b1;
    addr_sel = 2'h2;
    por_ev = 1'b0;
    rf = 1'b0;
    refc = 1'b0;
    repeat (16) @(posedge clock_in);
    #1;
    sys_rst_in = 1'b0;
    tick(4);
    t_reset();
    t_pairs();
    t_partial();
    t_address();
    t_tests();
    t_divider();
    t_dropout();
    wrap_up();
  end
endmodule
